// File: scp_defs.svh
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// Scratch-pad word locations
`define SCP_OFS_MODE 16'h0000
`define SCP_OFS_SUBCMD 16'h0002
`define SCP_OFS_RESULT 16'h0004
`define SCP_OFS_PASSWORD 16'h000A
`define SCP_OFS_TYPE 16'h0016

// Subcommand codes as the device sees them
`define SCP_SUB_LOGIN 16'h0009
`define SCP_SUB_CHANGE 16'h000A
`define SCP_SUB_CHECK 16'h0003
`define SCP_SUB_ERRLOC 16'h0006

// Error codes
`define SCP_ERR_NONE 8'h00
`define SCP_ERR_ZERO_LEN 8'h07
`define SCP_ERR_TOO_MUCH 8'h04
`define SCP_ERR_PROTECTED 8'h08
`define SCP_ERR_BAD_TYPE 8'h09

// Byte caps on the base model
`define SCP_BASE_TC_RD 16'h0074
`define SCP_BASE_IO_RD 16'h002E
`define SCP_BASE_IO_WR 16'h0003
`define SCP_BASE_UL_RD 16'h0096
`define SCP_BASE_UL_WR 16'h005A

// Byte caps on the junior model
`define SCP_JR_TC_RD 16'h002A
`define SCP_JR_IO_RD 16'h0016
`define SCP_JR_UL_RD 16'h0032
`define SCP_JR_UL_WR 16'h0028

// Reset values
`define SCP_RST_WORD 16'h0000

`endif

// File: scp_pkg.sv
package scp_pkg;

  typedef enum logic [1:0] {
    SCP_MODEL_BASE = 2'b00,
    SCP_MODEL_JUNIOR = 2'b01,
    SCP_MODEL_ENHANCED = 2'b10,
    SCP_MODEL_LARGE = 2'b11
  } scp_model_t;

  typedef enum logic [3:0] {
    SCP_MEM_TC = 4'h1,
    SCP_MEM_DREG = 4'h2,
    SCP_MEM_IO = 4'h3,
    SCP_MEM_SP = 4'h6,
    SCP_MEM_UL = 4'h7,
    SCP_MEM_DIAG = 4'h9
  } scp_mem_t;

  typedef enum logic [0:0] {
    SCP_CHK_IDLE = 1'b0,
    SCP_CHK_BUSY = 1'b1
  } scp_chk_state_t;

  // Master register image to device word: low byte travels in the upper lane
  function automatic logic [15:0] scp_sub_decode(input logic [15:0] img);
    scp_sub_decode = {img[7:0], img[15:8]};
  endfunction : scp_sub_decode

  function automatic logic scp_is_guarded(input logic [3:0] mtype);
    scp_is_guarded = (mtype == 4'h1) || (mtype == 4'h3) || (mtype == 4'h7);
  endfunction : scp_is_guarded

endpackage : scp_pkg

// File: scp_limit_check.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_limit_check #(
  parameter logic [15:0] SIZE_TC = 16'h0200,
  parameter logic [15:0] SIZE_DREG = 16'h0200,
  parameter logic [15:0] SIZE_IO = 16'h0080,
  parameter logic [15:0] SIZE_SP = 16'h0020,
  parameter logic [15:0] SIZE_UL = 16'h2000,
  parameter logic [15:0] SIZE_DIAG = 16'h000A
) (
  input wire logic [1:0] model_i,
  input wire logic write_i,
  input wire logic [3:0] mem_type_i,
  input wire logic [15:0] len_i,
  input wire logic locked_i,
  output logic [7:0] code_o
);

  logic [15:0] size_cap;
  logic type_ok;
  logic small_model;
  logic junior;

  always_comb begin
    type_ok = 1'b1;
    size_cap = 16'h0000;
    unique case (mem_type_i)
      4'h1: size_cap = SIZE_TC;
      4'h2: size_cap = SIZE_DREG;
      4'h3: size_cap = SIZE_IO;
      4'h6: size_cap = SIZE_SP;
      4'h7: size_cap = SIZE_UL;
      4'h9: size_cap = SIZE_DIAG;
      default: type_ok = 1'b0;
    endcase
  end

  assign small_model = (model_i == scp_pkg::SCP_MODEL_BASE) ||
                       (model_i == scp_pkg::SCP_MODEL_JUNIOR);
  assign junior = (model_i == scp_pkg::SCP_MODEL_JUNIOR);

  always_comb begin
    code_o = `SCP_ERR_NONE;
    if (!type_ok) begin
      code_o = `SCP_ERR_BAD_TYPE;
    end else if (len_i == 16'h0000) begin
      code_o = `SCP_ERR_ZERO_LEN;
    end else if (locked_i && scp_pkg::scp_is_guarded(mem_type_i)) begin
      code_o = `SCP_ERR_PROTECTED;
    end else if (len_i > size_cap) begin
      code_o = `SCP_ERR_TOO_MUCH;
    end else if (small_model) begin
      unique case (mem_type_i)
        4'h1: begin
          if (write_i) begin
            code_o = `SCP_ERR_BAD_TYPE;
          end else if (len_i > (junior ? `SCP_JR_TC_RD : `SCP_BASE_TC_RD)) begin
            code_o = `SCP_ERR_TOO_MUCH;
          end
        end
        4'h3: begin
          if (write_i && (junior || len_i > `SCP_BASE_IO_WR)) begin
            code_o = `SCP_ERR_TOO_MUCH;
          end else if (!write_i && len_i > (junior ? `SCP_JR_IO_RD : `SCP_BASE_IO_RD)) begin
            code_o = `SCP_ERR_TOO_MUCH;
          end
        end
        4'h7: begin
          if (write_i && len_i > (junior ? `SCP_JR_UL_WR : `SCP_BASE_UL_WR)) begin
            code_o = `SCP_ERR_TOO_MUCH;
          end else if (!write_i && len_i > (junior ? `SCP_JR_UL_RD : `SCP_BASE_UL_RD)) begin
            code_o = `SCP_ERR_TOO_MUCH;
          end
        end
        default: code_o = `SCP_ERR_NONE;
      endcase
    end
  end

endmodule : scp_limit_check

// File: scp_password.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_password (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic pw_wr_i,
  input wire logic [15:0] pw_data_i,
  input wire logic [15:0] pending_sub_i,
  input wire logic consume_i,
  output logic locked_o,
  output logic logged_in_o
);

  logic [15:0] password;
  logic logged_in;
  logic bcd_ok;
  logic do_login;
  logic do_change;

  // Each nibble must be a decimal digit
  assign bcd_ok = (pw_data_i[3:0] < 4'hA) && (pw_data_i[7:4] < 4'hA) &&
                  (pw_data_i[11:8] < 4'hA) && (pw_data_i[15:12] < 4'hA);
  assign do_login = pw_wr_i && (pending_sub_i == `SCP_SUB_LOGIN) &&
                    (pw_data_i == password);
  assign do_change = pw_wr_i && (pending_sub_i == `SCP_SUB_CHANGE) &&
                     logged_in && bcd_ok;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      password <= `SCP_RST_WORD;
    end else if (ce_i && do_change) begin
      password <= pw_data_i;
    end
  end

  // A login arriving with a consuming request wins
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      logged_in <= 1'b0;
    end else if (ce_i) begin
      if (do_login) begin
        logged_in <= 1'b1;
      end else if (consume_i) begin
        logged_in <= 1'b0;
      end
    end
  end

  assign locked_o = (password != `SCP_RST_WORD) && !logged_in;
  assign logged_in_o = logged_in;

endmodule : scp_password

// File: scp_core.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

module scp_core #(
  parameter logic [15:0] TYPE_CODE = 16'h005A, // Arbitrary identity value
  parameter logic [15:0] SIZE_TC = 16'h0200,
  parameter logic [15:0] SIZE_IO = 16'h0080,
  parameter logic [15:0] SIZE_UL = 16'h2000
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [1:0] model_i,
  input wire logic sp_wr_i,
  input wire logic sp_rd_i,
  input wire logic [15:0] sp_addr_i,
  input wire logic [15:0] sp_wdata_i,
  output logic sp_rvalid_o,
  output logic [15:0] sp_rdata_o,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [3:0] req_type_i,
  input wire logic [15:0] req_len_i,
  output logic resp_valid_o,
  output logic [7:0] resp_code_o,
  output logic [15:0] run_mode_o,
  output logic check_start_o,
  input wire logic check_done_i,
  input wire logic [15:0] check_code_i,
  input wire logic [15:0] check_addr_i,
  output logic locked_o
);

  scp_pkg::scp_chk_state_t chk_state;
  logic [15:0] controller_run_mode;
  logic [15:0] check_result_word;
  logic [15:0] pending_sub;
  logic [15:0] err_location;
  logic [15:0] sub_word;
  logic [7:0] limit_code;
  logic enhanced;
  logic locked;
  logic logged_in;
  logic wr_sub;
  logic wr_pw;
  logic consume;

  assign enhanced = (model_i == scp_pkg::SCP_MODEL_ENHANCED);
  assign sub_word = scp_pkg::scp_sub_decode(sp_wdata_i);
  assign wr_sub = sp_wr_i && (sp_addr_i == `SCP_OFS_SUBCMD) && enhanced;
  assign wr_pw = sp_wr_i && (sp_addr_i == `SCP_OFS_PASSWORD) && enhanced;
  assign consume = req_valid_i && scp_pkg::scp_is_guarded(req_type_i);

  scp_password u_password (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pw_wr_i(wr_pw),
    .pw_data_i(sp_wdata_i),
    .pending_sub_i(pending_sub),
    .consume_i(consume),
    .locked_o(locked),
    .logged_in_o(logged_in)
  );

  scp_limit_check #(
    .SIZE_TC(SIZE_TC),
    .SIZE_IO(SIZE_IO),
    .SIZE_UL(SIZE_UL)
  ) u_limit (
    .model_i(model_i),
    .write_i(req_write_i),
    .mem_type_i(req_type_i),
    .len_i(req_len_i),
    .locked_i(locked && enhanced),
    .code_o(limit_code)
  );

  // Transfer request answer, one cycle after the request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_valid_o <= 1'b0;
      resp_code_o <= `SCP_ERR_NONE;
    end else if (ce_i) begin
      resp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        resp_code_o <= limit_code;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_o <= 1'b0;
    end else if (ce_i) begin
      locked_o <= locked && enhanced;
    end
  end

  // Controller mode is common to all models
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      controller_run_mode <= `SCP_RST_WORD;
    end else if (ce_i && sp_wr_i && sp_addr_i == `SCP_OFS_MODE) begin
      controller_run_mode <= sp_wdata_i;
    end
  end

  assign run_mode_o = controller_run_mode;

  // Login and change wait for the password word; check and error location clear it, other codes are ignored
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_sub <= `SCP_RST_WORD;
    end else if (ce_i && wr_sub) begin
      if (sub_word == `SCP_SUB_LOGIN || sub_word == `SCP_SUB_CHANGE) begin
        pending_sub <= sub_word;
      end else if (sub_word == `SCP_SUB_CHECK || sub_word == `SCP_SUB_ERRLOC) begin
        pending_sub <= `SCP_RST_WORD;
      end
    end
  end

  // Program check sequencer; runs whatever the controller mode
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chk_state <= scp_pkg::SCP_CHK_IDLE;
      check_start_o <= 1'b0;
    end else if (ce_i) begin
      check_start_o <= 1'b0;
      unique case (chk_state)
        scp_pkg::SCP_CHK_IDLE: begin
          if (wr_sub && sub_word == `SCP_SUB_CHECK) begin
            check_start_o <= 1'b1;
            chk_state <= scp_pkg::SCP_CHK_BUSY;
          end
        end
        scp_pkg::SCP_CHK_BUSY: begin
          if (check_done_i) begin
            chk_state <= scp_pkg::SCP_CHK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_location <= `SCP_RST_WORD;
    end else if (ce_i && chk_state == scp_pkg::SCP_CHK_BUSY && check_done_i) begin
      err_location <= check_addr_i;
    end
  end

  // Result word: check code or error location
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      check_result_word <= `SCP_RST_WORD;
    end else if (ce_i) begin
      if (chk_state == scp_pkg::SCP_CHK_BUSY && check_done_i) begin
        check_result_word <= check_code_i;
      end else if (wr_sub && sub_word == `SCP_SUB_ERRLOC) begin
        check_result_word <= err_location;
      end
    end
  end

  // Scratch-pad read port
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_rvalid_o <= 1'b0;
      sp_rdata_o <= `SCP_RST_WORD;
    end else if (ce_i) begin
      sp_rvalid_o <= sp_rd_i;
      if (sp_rd_i) begin
        unique case (sp_addr_i)
          `SCP_OFS_MODE: sp_rdata_o <= controller_run_mode;
          `SCP_OFS_RESULT: sp_rdata_o <= enhanced ? check_result_word : `SCP_RST_WORD;
          `SCP_OFS_TYPE: sp_rdata_o <= TYPE_CODE;
          default: sp_rdata_o <= `SCP_RST_WORD;
        endcase
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Transfer answers
  resp_timing_a: assert property (ce_i && req_valid_i |=> resp_valid_o)
    else $error("answer missing after request");
  locked_code_a: assert property (ce_i && req_valid_i && locked && enhanced &&
      scp_pkg::scp_is_guarded(req_type_i) && req_len_i != 16'h0000 &&
      req_type_i != 4'h2 |=> resp_code_o == 8'h08)
    else $error("locked request not refused with 08");
  tc_read_cap_a: assert property (ce_i && req_valid_i && model_i == 2'b00 &&
      !req_write_i && req_type_i == 4'h1 && req_len_i == 16'h0075
      |=> resp_code_o == 8'h04)
    else $error("accumulator read cap wrong");
  tc_write_a: assert property (ce_i && req_valid_i && model_i == 2'b01 && req_write_i &&
      req_type_i == 4'h1 && req_len_i == 16'h0002 |=> resp_code_o == 8'h09)
    else $error("accumulator write not refused");
  tc_base_write_a: assert property (ce_i && req_valid_i && model_i == 2'b00 &&
      req_write_i && req_type_i == 4'h1 && req_len_i == 16'h0002 |=> resp_code_o == 8'h09)
    else $error("base accumulator write not refused");
  jr_io_write_a: assert property (ce_i && req_valid_i && model_i == 2'b01 && req_write_i &&
      req_type_i == 4'h3 && req_len_i == 16'h0001 |=> resp_code_o == 8'h04)
    else $error("junior output write not refused");
  io_read_cap_a: assert property (ce_i && req_valid_i && model_i == 2'b01 &&
      !req_write_i && req_type_i == 4'h3 && req_len_i == 16'h0017 |=> resp_code_o == 8'h04)
    else $error("junior I/O read cap wrong");
  ul_read_cap_a: assert property (ce_i && req_valid_i && model_i == 2'b01 &&
      !req_write_i && req_type_i == 4'h7 && req_len_i == 16'h0033 |=> resp_code_o == 8'h04)
    else $error("junior user-logic read cap wrong");
  ul_write_cap_a: assert property (ce_i && req_valid_i && model_i == 2'b00 &&
      req_write_i && req_type_i == 4'h7 && req_len_i == 16'h005B |=> resp_code_o == 8'h04)
    else $error("base user-logic write cap wrong");
  large_ok_a: assert property (ce_i && req_valid_i && model_i == 2'b11 &&
      req_type_i == 4'h7 && req_len_i == SIZE_UL |=> resp_code_o == 8'h00)
    else $error("large model refused legal size");
  bad_type_a: assert property (ce_i && req_valid_i && req_type_i == 4'h4
      |=> resp_code_o == 8'h09)
    else $error("invalid memory type not refused");
  zero_len_a: assert property (ce_i && req_valid_i && req_type_i == 4'h7 &&
      req_len_i == 16'h0000 |=> resp_code_o == 8'h07)
    else $error("zero length not refused");

  // Scratch-pad port and clock enable
  rd_timing_a: assert property (ce_i && sp_rd_i |=> sp_rvalid_o)
    else $error("read answer missing");
  type_read_a: assert property (ce_i && sp_rd_i && sp_addr_i == 16'h0016
      |=> sp_rdata_o == TYPE_CODE)
    else $error("controller type word wrong");
  result_hide_a: assert property (ce_i && sp_rd_i && sp_addr_i == 16'h0004 &&
      !enhanced |=> sp_rdata_o == 16'h0000)
    else $error("result word visible off the enhanced model");
  mode_write_a: assert property (ce_i && sp_wr_i && sp_addr_i == 16'h0000
      |=> run_mode_o == $past(sp_wdata_i))
    else $error("controller mode not stored");
  ce_freeze_a: assert property (!ce_i |=> $stable(run_mode_o) && $stable(resp_valid_o) &&
      $stable(sp_rvalid_o) && $stable(locked_o) && $stable(check_result_word))
    else $error("state moved while clock enable low");

  // Password and program check
  check_start_a: assert property (ce_i && sp_wr_i && sp_addr_i == 16'h0002 &&
      sp_wdata_i == 16'h0300 && model_i == 2'b10 && chk_state == scp_pkg::SCP_CHK_IDLE
      |=> check_start_o ##1 !check_start_o || !$past(ce_i))
    else $error("program check not started");
  busy_start_a: assert property (ce_i && chk_state == scp_pkg::SCP_CHK_BUSY
      |=> !check_start_o)
    else $error("check restarted while busy");
  result_load_a: assert property (ce_i && chk_state == scp_pkg::SCP_CHK_BUSY &&
      check_done_i |=> check_result_word == $past(check_code_i))
    else $error("check code not placed in result word");
  errloc_a: assert property (ce_i && wr_sub && sub_word == 16'h0006 &&
      !(chk_state == scp_pkg::SCP_CHK_BUSY && check_done_i)
      |=> check_result_word == $past(err_location))
    else $error("error location not placed in result word");
  unknown_sub_a: assert property (ce_i && wr_sub && sub_word == 16'h0005 &&
      chk_state == scp_pkg::SCP_CHK_IDLE |=> $stable(check_result_word) &&
      $stable(pending_sub))
    else $error("unknown subcommand changed state");
  login_use_a: assert property (ce_i && consume && !wr_pw && logged_in
      |=> !logged_in)
    else $error("login not consumed by guarded request");
  change_gate_a: assert property (ce_i && wr_pw && pending_sub == 16'h000A &&
      !logged_in |=> $stable(locked))
    else $error("password changed without login");
  locked_out_a: assert property (ce_i |=> locked_o == ($past(locked) && $past(enhanced)))
    else $error("lock flag does not follow password state");

  login_c: cover property (wr_pw && pending_sub == 16'h0009 && !locked ##1 logged_in);
  check_c: cover property (check_start_o ##[1:20] check_done_i);
  lock_c: cover property (resp_valid_o && resp_code_o == 8'h08);
  errloc_c: cover property (wr_sub && sub_word == 16'h0006 ##1 check_result_word != 16'h0000);
  freeze_c: cover property (!ce_i ##1 !ce_i);

endmodule : scp_core

// File: scp_checker_model.sv
`timescale 1ns/1ps

module scp_checker_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [7:0] delay_i,
  input wire logic [15:0] code_i,
  input wire logic [15:0] addr_i,
  output logic done_o,
  output logic [15:0] code_o,
  output logic [15:0] addr_o
);
  logic busy;
  logic [7:0] cnt;

  // Program checker: answers a start after a chosen delay with one done pulse
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      done_o <= 1'b0;
      code_o <= 16'h0000;
      addr_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      // Result lines are only valid with done; scramble them otherwise
      code_o <= ~code_o;
      addr_o <= ~addr_o;
      if (start_i && !busy) begin
        busy <= 1'b1;
        cnt <= delay_i;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        code_o <= code_i;
        addr_o <= addr_i;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : scp_checker_model

// File: scratchpad_password_and_check_bench.sv
`timescale 1ns/1ps

module scratchpad_password_and_check_bench;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] model_i = 2'b00;
  logic sp_wr_i = 1'b0;
  logic sp_rd_i = 1'b0;
  logic [15:0] sp_addr_i = 16'h0000;
  logic [15:0] sp_wdata_i = 16'h0000;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [3:0] req_type_i = 4'h0;
  logic [15:0] req_len_i = 16'h0000;
  logic [7:0] chk_delay = 8'h01;
  logic [15:0] chk_code = 16'h0000;
  logic [15:0] chk_addr = 16'h0000;
  logic sp_rvalid_o, resp_valid_o, check_start_o, check_done, locked_o;
  logic [15:0] sp_rdata_o, run_mode_o, check_code, check_addr;
  logic [7:0] resp_code_o;
  logic [7:0] code_q[$];
  logic [15:0] word_q[$];
  int fail_count = 0;
  int checks_done = 0;
  logic [1:0] lm[9] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b01, 2'b01, 2'b01, 2'b01};
  logic lw[9] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [3:0] lt[9] = '{4'h1, 4'h3, 4'h3, 4'h7, 4'h7, 4'h1, 4'h3, 4'h7, 4'h7};
  logic [15:0] lc[9] = '{16'h0074, 16'h002E, 16'h0003, 16'h0096, 16'h005A,
                         16'h002A, 16'h0016, 16'h0032, 16'h0028};

  always #20 clock_i = ~clock_i;

  scp_core #(.TYPE_CODE(16'h005A), .SIZE_TC(16'h0200), .SIZE_IO(16'h0080),
             .SIZE_UL(16'h2000)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .model_i(model_i),
    .sp_wr_i(sp_wr_i), .sp_rd_i(sp_rd_i), .sp_addr_i(sp_addr_i), .sp_wdata_i(sp_wdata_i),
    .sp_rvalid_o(sp_rvalid_o), .sp_rdata_o(sp_rdata_o), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_type_i(req_type_i), .req_len_i(req_len_i),
    .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o), .run_mode_o(run_mode_o),
    .check_start_o(check_start_o), .check_done_i(check_done), .check_code_i(check_code),
    .check_addr_i(check_addr), .locked_o(locked_o));

  scp_checker_model partner (
    .clock_i(clock_i), .nrst_i(nrst_i), .start_i(check_start_o), .delay_i(chk_delay),
    .code_i(chk_code), .addr_i(chk_addr), .done_o(check_done), .code_o(check_code),
    .addr_o(check_addr));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic cmp_code(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t code got %h exp %h", $time, got, exp);
    end
  endtask : cmp_code

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flag

  // Results are taken oldest first as the design presents them
  always @(posedge clock_i) begin
    if (resp_valid_o === 1'b1) begin
      if (code_q.size() == 0) cmp_code(resp_code_o, 8'hFF);
      else cmp_code(resp_code_o, code_q.pop_front());
    end
    if (sp_rvalid_o === 1'b1) begin
      if (word_q.size() == 0) cmp_word(sp_rdata_o, 16'hFFFF);
      else cmp_word(sp_rdata_o, word_q.pop_front());
    end
  end

  task automatic sp_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    sp_wr_i <= 1'b1;
    sp_addr_i <= a;
    sp_wdata_i <= d;
    @(posedge clock_i);
    sp_wr_i <= 1'b0;
    sp_wdata_i <= ~d;
  endtask : sp_write

  task automatic sp_read(input logic [15:0] a, input logic [15:0] exp);
    word_q.push_back(exp);
    @(posedge clock_i);
    sp_rd_i <= 1'b1;
    sp_addr_i <= a;
    @(posedge clock_i);
    sp_rd_i <= 1'b0;
  endtask : sp_read

  task automatic req(input logic w, input logic [3:0] t, input logic [15:0] n,
                     input logic [7:0] exp);
    code_q.push_back(exp);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_type_i <= t;
    req_len_i <= n;
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask : req

  // Five-word block: subcommand image with bytes swapped, three zeros, password
  task automatic five_words(input logic [15:0] sub_img, input logic [15:0] pw);
    sp_write(16'h0002, sub_img);
    sp_write(16'h0004, 16'h0000);
    sp_write(16'h0006, 16'h0000);
    sp_write(16'h0008, 16'h0000);
    sp_write(16'h000A, pw);
  endtask : five_words

  task automatic run_check(input logic [7:0] dly, input logic [15:0] c, input logic [15:0] a);
    chk_delay <= dly;
    chk_code <= c;
    chk_addr <= a;
    sp_write(16'h0002, 16'h0300);
    repeat (int'(dly) + 6) @(posedge clock_i);
  endtask : run_check

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h0009));
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    sp_read(16'h0000, 16'h0000);
    sp_read(16'h0016, 16'h005A);
    sp_read(16'h0004, 16'h0000);
    @(negedge clock_i);
    cmp_word(run_mode_o, 16'h0000);
    cmp_flag(locked_o, 1'b0);
    $display("test reset_reads done");
    for (int i = 0; i < 9; i++) begin
      model_i <= lm[i];
      req(lw[i], lt[i], lc[i], 8'h00);
      req(lw[i], lt[i], lc[i] + 16'h0001, 8'h04);
      req(lw[i], lt[i], 16'h0001 + 16'($urandom % lc[i]), 8'h00);
    end
    req(1'b1, 4'h1, 16'h0002, 8'h09);
    req(1'b1, 4'h3, 16'h0001, 8'h04);
    model_i <= 2'b00;
    req(1'b1, 4'h1, 16'h0002, 8'h09);
    req(1'b0, 4'h6, 16'h0020, 8'h00);
    $display("test size_caps done");
    model_i <= 2'b11;
    req(1'b0, 4'h1, 16'h0200, 8'h00);
    req(1'b0, 4'h3, 16'h0080, 8'h00);
    req(1'b0, 4'h3, 16'h0081, 8'h04);
    req(1'b0, 4'h7, 16'h2000, 8'h00);
    req(1'b1, 4'h7, 16'h2002, 8'h04);
    req(1'b0, 4'h4, 16'h0002, 8'h09);
    req(1'b0, 4'h7, 16'h0000, 8'h07);
    $display("test large_model done");
    model_i <= 2'b10;
    req(1'b0, 4'h7, 16'h0002, 8'h00);
    five_words(16'h0900, 16'h0000);
    five_words(16'h0A00, 16'h1234);
    req(1'b0, 4'h7, 16'h0002, 8'h00);
    req(1'b0, 4'h7, 16'h0002, 8'h08);
    @(negedge clock_i);
    cmp_flag(locked_o, 1'b1);
    req(1'b0, 4'h6, 16'h0002, 8'h00);
    req(1'b0, 4'h9, 16'h000A, 8'h00);
    five_words(16'h0900, 16'h1111);
    req(1'b0, 4'h1, 16'h0002, 8'h08);
    five_words(16'h0A00, 16'h0000);
    five_words(16'h0900, 16'h1234);
    repeat (2) @(negedge clock_i);
    cmp_flag(locked_o, 1'b0);
    sp_write(16'h0002, 16'h0500);
    req(1'b1, 4'h3, 16'h0001, 8'h00);
    req(1'b0, 4'h3, 16'h0001, 8'h08);
    $display("test password done");
    run_check(8'h09, 16'h0015, 16'h0123);
    sp_read(16'h0004, 16'h0015);
    sp_write(16'h0002, 16'h0500);
    sp_read(16'h0004, 16'h0015);
    sp_write(16'h0002, 16'h0600);
    sp_read(16'h0004, 16'h0123);
    sp_write(16'h0000, 16'h0001);
    @(negedge clock_i);
    cmp_word(run_mode_o, 16'h0001);
    sp_read(16'h0000, 16'h0001);
    run_check(8'h01, 16'h0000, 16'h0042);
    sp_read(16'h0004, 16'h0000);
    $display("test program_check done");
    model_i <= 2'b00;
    run_check(8'h01, 16'h0033, 16'h0044);
    sp_read(16'h0004, 16'h0000);
    req(1'b0, 4'h7, 16'h0002, 8'h00);
    @(negedge clock_i);
    cmp_flag(locked_o, 1'b0);
    sp_read(16'h0000, 16'h0001);
    // Clock enable low: a mode write must be ignored and the mode kept
    repeat (2) @(posedge clock_i);
    ce_i <= 1'b0;
    sp_write(16'h0000, 16'h00A5);
    ce_i <= 1'b1;
    sp_read(16'h0000, 16'h0001);
    @(negedge clock_i);
    cmp_word(run_mode_o, 16'h0001);
    $display("test base_model done");
    repeat (4) @(posedge clock_i);
    if (code_q.size() != 0 || word_q.size() != 0) fail_count++;
    print_verdict();
  end
endmodule : scratchpad_password_and_check_bench
